// [include/rtc_regs_pkg.sv]
/*
 Register map, field positions, reset values and timing counts of the
 RTC control and status register bank.
 Assumes a 100 MHz system clock and a 65.536 kHz oscillator core clock.
*/
package rtc_regs_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_FIRST     = 8'h00;
   localparam logic [7:0] ADDR_CONTROL   = 8'h0e;
   localparam logic [7:0] ADDR_STATUS    = 8'h0f;
   localparam logic [7:0] ADDR_AGING     = 8'h10;
   localparam logic [7:0] ADDR_TEMP_INT  = 8'h11;
   localparam logic [7:0] ADDR_TEMP_FRAC = 8'h12;
   // Control fields
   localparam int BIT_OSC_DIS  = 7;
   localparam int BIT_BB_SQW   = 6;
   localparam int BIT_FORCE_TEMP_CONVERT     = 5;
   localparam int BIT_RS_HI    = 4;
   localparam int BIT_RS_LO    = 3;
   localparam int BIT_INT_MODE = 2;
   localparam int BIT_ALARM2_IRQ_EN     = 1;
   localparam int BIT_ALARM1_IRQ_EN     = 0;
   // Status fields
   localparam int BIT_OSF    = 7;
   localparam int BIT_CLK_EN = 3;
   localparam int BIT_BUSY   = 2;
   localparam int BIT_A2F    = 1;
   localparam int BIT_A1F    = 0;
   // Reset values
   localparam logic [7:0] CONTROL_RST = 8'h1c;
   localparam logic [7:0] AGING_RST   = 8'h00;
   localparam logic [9:0] TEMP_RST    = 10'h000;
   localparam logic       OSF_RST     = 1'b1;
   localparam logic       CLK_EN_RST  = 1'b1;
   localparam logic       FLAG_RST    = 1'b0;
   // Divider taps of the oscillator core counter
   localparam int TAP_32K = 0;
   localparam int TAP_8K  = 2;
   localparam int TAP_4K  = 3;
   localparam int TAP_1K  = 5;
   localparam int TAP_1HZ = 15;
   // Timing
   localparam int CLK_MHZ       = 100;
   localparam int USER_BUSY_US  = 2000;
   localparam int USER_BUSY_CYC = USER_BUSY_US * CLK_MHZ;
   localparam int PERIOD_SEC    = 64;
   // Conversion sequencer states
   typedef enum logic [1:0]
   {
      ST_IDLE    = 2'b00,
      ST_MEASURE = 2'b01,
      ST_COMP    = 2'b10
   } force_temp_convert_state_e;
endpackage : rtc_regs_pkg

// [hdl/rtc_control_status_regs.sv]
/*
 Control, status, aging and temperature registers of a real-time clock.
 Assumes the serial slave delivers pointer loads, byte reads and writes as
 one-cycle pulses on clk_in; osc_clk_in is the oscillator core at 65.536 kHz.
*/
// Summary of operation
// - Oscillator stops only on battery with disable set
// - Stopped oscillator freezes registers; disable resets 0
// - Battery wave only with enable and wave mode
// - Convert write starts only when sequencer idle
// - Convert bit and busy clear together
// - User conversion delays busy; periodic timing untouched
// - Rate field selects 1Hz to 8.192kHz; resets 11
// - Mode bit picks wave or alarm interrupt
// - Alarm flags set regardless of mode
// - Alarm 2 drives pin with enable and mode when off battery
// - Alarm 1 drives pin with enable and mode when off battery
// - Oscillator stop sets sticky flag, software clears
// - Clock pin outputs 32.768kHz when enabled
// - Busy rises at automatic trigger, falls when done
// - Alarm flags clear on zero, ignore one
// - Aging is signed byte added to capacitance
// - Aging applied on changed or user conversion
// - Positive aging adds capacitance, lowers frequency
// - Temperature ten bits, quarter degree steps
// - Reset gives zero degrees and starts conversion
// - Convert at power, battery access, every 64s
// - Temperature registers ignore writes
// - Alarm match sampled on second update
// - Pointer wraps from last register to zero
`timescale 1ns/1ps
module rtc_control_status_regs
#(
   parameter int USER_BUSY_CYCLES = rtc_regs_pkg::USER_BUSY_CYC
)
(
   // Clocks and reset
   input  wire logic       clk_in,
   input  wire logic       osc_clk_in,
   input  wire logic       rstn_in,
   // Register port from the serial slave
   input  wire logic       ptr_load_in,
   input  wire logic [7:0] ptr_value_in,
   input  wire logic       reg_wr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   output logic      [7:0] reg_ptr_out,
   // Supply and timekeeping
   input  wire logic       on_battery_in,
   input  wire logic       osc_fail_in,
   input  wire logic       second_tick_in,
   input  wire logic       alarm1_hit_in,
   input  wire logic       alarm2_hit_in,
   // Temperature sensor and capacitance array
   output logic            temp_force_temp_convert_out,
   input  wire logic       temp_done_in,
   input  wire logic [9:0] temp_value_in,
   input  wire logic [7:0] cap_base_in,
   output logic      [7:0] cap_code_out,
   output logic            osc_run_out,
   // Pins
   output logic            irq_or_wave_n_out,
   output logic            irq_or_wave_n_oe_out,
   output logic            clk32_out,
   output logic            clk32_oe_out
);
   import rtc_regs_pkg::*;

   logic        rst_meta, rstn;
   logic        orst_meta, orstn;
   logic        batt_meta, on_batt, fail_meta, fail_s;
   logic        wave_meta, wave_s;
   logic        osc_disable_on_battery, battery_square_wave_en;
   logic        force_temp_convert, interrupt_mode_select;
   logic [1:0]  rate_select;
   logic        alarm2_irq_en, alarm1_irq_en;
   logic        osc_stopped_flag, clk_out_enable, compensation_busy;
   logic        alarm2_match_flag, alarm1_match_flag;
   logic [7:0]  crystal_aging_offset;
   logic [9:0]  temp_reg;
   logic [5:0]  period_cnt;
   logic        auto_pend, from_user, temp_changed, cen_src;
   logic [31:0] dly;
   force_temp_convert_state_e state;
   logic        frozen, user_req, auto_set;
   logic signed [9:0] next_cap;
   // Oscillator domain
   logic [15:0] div;
   logic [1:0]  rs_meta, rs_sync, rs_prev, rs_s;
   logic        cen_meta, cen_s, wave_sel;

   function automatic logic wr_to(input logic [7:0] a);
      wr_to = reg_wr_in && !ptr_load_in && !frozen && reg_ptr_out == a;
   endfunction : wr_to

   function automatic logic [7:0] reg_read(input logic [7:0] a);
      case (a)
         ADDR_CONTROL:   reg_read = {osc_disable_on_battery, battery_square_wave_en, force_temp_convert,
                                     rate_select, interrupt_mode_select, alarm2_irq_en, alarm1_irq_en};
         ADDR_STATUS:    reg_read = {osc_stopped_flag, 3'b000, clk_out_enable, compensation_busy,
                                     alarm2_match_flag, alarm1_match_flag};
         ADDR_AGING:     reg_read = crystal_aging_offset;
         ADDR_TEMP_INT:  reg_read = temp_reg[9:2];
         ADDR_TEMP_FRAC: reg_read = {temp_reg[1:0], 6'b000000};
         default:        reg_read = 8'h00;
      endcase
   endfunction : reg_read

   // Reset release and pin synchronisers
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rst_meta <= 1'b0;
         rstn     <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rstn     <= rst_meta;
      end
   end

   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
      begin
         batt_meta <= 1'b0;
         on_batt   <= 1'b0;
         fail_meta <= 1'b0;
         fail_s    <= 1'b0;
         wave_meta <= 1'b0;
         wave_s    <= 1'b0;
      end
      else
      begin
         batt_meta <= on_battery_in;
         on_batt   <= batt_meta;
         fail_meta <= osc_fail_in;
         fail_s    <= fail_meta;
         wave_meta <= wave_sel;
         wave_s    <= wave_meta;
      end
   end

   assign frozen   = osc_disable_on_battery && on_batt;
   // Written out in full: a function call here would not follow the bus signals it reads
   assign user_req = reg_wr_in && !ptr_load_in && !frozen && reg_ptr_out == ADDR_CONTROL
                     && reg_wdata_in[BIT_FORCE_TEMP_CONVERT];

   // Oscillator run control and stop flag
   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
      begin
         osc_run_out      <= 1'b1;
         osc_stopped_flag <= OSF_RST;
      end
      else
      begin
         osc_run_out <= !frozen;
         if ((osc_run_out && frozen) || fail_s)
            osc_stopped_flag <= 1'b1;
         else if (wr_to(ADDR_STATUS) && !reg_wdata_in[BIT_OSF])
            osc_stopped_flag <= 1'b0;
      end
   end

   // Configuration bits and aging offset
   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
      begin
         osc_disable_on_battery <= CONTROL_RST[BIT_OSC_DIS];
         battery_square_wave_en <= CONTROL_RST[BIT_BB_SQW];
         rate_select            <= CONTROL_RST[BIT_RS_HI:BIT_RS_LO];
         interrupt_mode_select  <= CONTROL_RST[BIT_INT_MODE];
         alarm2_irq_en          <= CONTROL_RST[BIT_ALARM2_IRQ_EN];
         alarm1_irq_en          <= CONTROL_RST[BIT_ALARM1_IRQ_EN];
         clk_out_enable         <= CLK_EN_RST;
         crystal_aging_offset   <= AGING_RST;
      end
      else
      begin
         if (wr_to(ADDR_CONTROL))
         begin
            osc_disable_on_battery <= reg_wdata_in[BIT_OSC_DIS];
            battery_square_wave_en <= reg_wdata_in[BIT_BB_SQW];
            rate_select            <= reg_wdata_in[BIT_RS_HI:BIT_RS_LO];
            interrupt_mode_select  <= reg_wdata_in[BIT_INT_MODE];
            alarm2_irq_en          <= reg_wdata_in[BIT_ALARM2_IRQ_EN];
            alarm1_irq_en          <= reg_wdata_in[BIT_ALARM1_IRQ_EN];
         end
         if (wr_to(ADDR_STATUS))
            clk_out_enable <= reg_wdata_in[BIT_CLK_EN];
         if (wr_to(ADDR_AGING))
            crystal_aging_offset <= reg_wdata_in;
      end
   end

   // Alarm flags: a match on the second update wins over a clearing write
   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
      begin
         alarm1_match_flag <= FLAG_RST;
         alarm2_match_flag <= FLAG_RST;
      end
      else
      begin
         if (second_tick_in && alarm1_hit_in && !frozen)
            alarm1_match_flag <= 1'b1;
         else if (wr_to(ADDR_STATUS) && !reg_wdata_in[BIT_A1F])
            alarm1_match_flag <= 1'b0;
         if (second_tick_in && alarm2_hit_in && !frozen)
            alarm2_match_flag <= 1'b1;
         else if (wr_to(ADDR_STATUS) && !reg_wdata_in[BIT_A2F])
            alarm2_match_flag <= 1'b0;
      end
   end

   // Register pointer and read data
   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_ptr_out   <= ADDR_FIRST;
         reg_rdata_out <= 8'h00;
      end
      else if (ptr_load_in)
         reg_ptr_out <= ptr_value_in;
      else if (reg_wr_in || reg_rd_in)
      begin
         if (reg_rd_in)
            reg_rdata_out <= reg_read(reg_ptr_out);
         if (reg_ptr_out == ADDR_TEMP_FRAC)
            reg_ptr_out <= ADDR_FIRST;
         else
            reg_ptr_out <= reg_ptr_out + 8'h01;
      end
   end

   // Periodic schedule counts second updates, so user conversions never shift it
   assign auto_set = (second_tick_in && !frozen && period_cnt == 6'(PERIOD_SEC - 1))
                     || (on_batt && !frozen && (reg_wr_in || reg_rd_in));

   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
         period_cnt <= 6'h00;
      else if (second_tick_in && !frozen)
         period_cnt <= period_cnt + 6'h01;
   end

   // Capacitance code with sign-extended aging, clamped to the array range
   always_comb
   begin
      next_cap = $signed({2'b00, cap_base_in}) + $signed({{2{crystal_aging_offset[7]}}, crystal_aging_offset});
      if (next_cap < 0)
         next_cap = 10'sh000;
      else if (next_cap > 10'sh0ff)
         next_cap = 10'sh0ff;
   end

   // Conversion sequencer
   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
      begin
         state              <= ST_IDLE;
         auto_pend          <= 1'b1;
         force_temp_convert <= 1'b0;
         compensation_busy  <= 1'b0;
         from_user          <= 1'b0;
         temp_changed       <= 1'b0;
         temp_force_temp_convert_out      <= 1'b0;
         dly                <= 32'h0000_0000;
         temp_reg           <= TEMP_RST;
         cap_code_out       <= 8'h00;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (auto_set)
                  auto_pend <= 1'b1;
               if (frozen)
                  state <= ST_IDLE;
               else if (user_req)
               begin
                  state              <= ST_MEASURE;
                  force_temp_convert <= 1'b1;
                  from_user          <= 1'b1;
                  temp_force_temp_convert_out      <= 1'b1;
                  dly                <= 32'h0000_0000;
               end
               else if (auto_pend)
               begin
                  state             <= ST_MEASURE;
                  auto_pend         <= auto_set;
                  compensation_busy <= 1'b1;
                  from_user         <= 1'b0;
                  temp_force_temp_convert_out     <= 1'b1;
               end
            end
            ST_MEASURE:
            begin
               if (auto_set)
                  auto_pend <= 1'b1;
               if (from_user && dly != 32'(USER_BUSY_CYCLES))
                  dly <= dly + 32'h0000_0001;
               else if (from_user)
                  compensation_busy <= 1'b1;
               if (temp_done_in)
               begin
                  state         <= ST_COMP;
                  temp_force_temp_convert_out <= 1'b0;
                  temp_changed  <= temp_value_in != temp_reg;
                  temp_reg      <= temp_value_in;
               end
            end
            ST_COMP:
            begin
               if (auto_set)
                  auto_pend <= 1'b1;
               if (from_user || temp_changed)
                  cap_code_out <= next_cap[7:0];
               state              <= ST_IDLE;
               force_temp_convert <= 1'b0;
               compensation_busy  <= 1'b0;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Combined pin: off battery, driven square wave in wave mode or low for an enabled alarm flag in interrupt mode; on battery, wave only with its enable
   always_ff @(posedge clk_in or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_or_wave_n_out    <= 1'b1;
         irq_or_wave_n_oe_out <= 1'b0;
         cen_src              <= 1'b0;
      end
      else
      begin
         cen_src <= clk_out_enable && !frozen;
         if (on_batt)
         begin
            irq_or_wave_n_out    <= wave_s;
            irq_or_wave_n_oe_out <= battery_square_wave_en && !interrupt_mode_select;
         end
         else if (!interrupt_mode_select)
         begin
            irq_or_wave_n_out    <= wave_s;
            irq_or_wave_n_oe_out <= 1'b1;
         end
         else
         begin
            irq_or_wave_n_out    <= 1'b0;
            irq_or_wave_n_oe_out <= (alarm1_irq_en && alarm1_match_flag)
                                    || (alarm2_irq_en && alarm2_match_flag);
         end
      end
   end

   // Oscillator domain: reset release, settings crossing and dividers
   always_ff @(posedge osc_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         orst_meta <= 1'b0;
         orstn     <= 1'b0;
      end
      else
      begin
         orst_meta <= 1'b1;
         orstn     <= orst_meta;
      end
   end

   always_ff @(posedge osc_clk_in or negedge orstn)
   begin
      if (!orstn)
      begin
         rs_meta      <= 2'b00;
         rs_sync      <= 2'b00;
         rs_prev      <= 2'b00;
         rs_s         <= 2'b00;
         cen_meta     <= 1'b0;
         cen_s        <= 1'b0;
         div          <= 16'h0000;
         wave_sel     <= 1'b0;
         clk32_out    <= 1'b0;
         clk32_oe_out <= 1'b0;
      end
      else
      begin
         rs_meta      <= rate_select;
         rs_sync      <= rs_meta;
         rs_prev      <= rs_sync;
         // Two bits may land on different edges; only a settled code selects the tap
         if (rs_sync == rs_prev)
            rs_s <= rs_sync;
         cen_meta     <= cen_src;
         cen_s        <= cen_meta;
         div          <= div + 16'h0001;
         clk32_out    <= div[TAP_32K];
         clk32_oe_out <= cen_s;
         case (rs_s)
            2'b00:   wave_sel <= div[TAP_1HZ];
            2'b01:   wave_sel <= div[TAP_1K];
            2'b10:   wave_sel <= div[TAP_4K];
            default: wave_sel <= div[TAP_8K];
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn);

   sequence s_user_start;
      state == ST_IDLE && !frozen && user_req;
   endsequence

   sequence s_force_temp_convert_done;
      state == ST_COMP;
   endsequence

   property p_osc_stop;
      frozen |=> !osc_run_out;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator runs while disabled on battery");

   property p_force_temp_convert_end;
      s_force_temp_convert_done |=> !force_temp_convert && !compensation_busy && state == ST_IDLE;
   endproperty
   a_force_temp_convert_end: assert property (p_force_temp_convert_end) else $error("convert and busy did not clear together");

   property p_busy_delay;
      s_user_start |=> (!compensation_busy && force_temp_convert) [*8];
   endproperty
   a_busy_delay: assert property (p_busy_delay) else $error("busy rose early on user conversion");

   property p_flag_clear;
      reg_wr_in && !ptr_load_in && !frozen && reg_ptr_out == ADDR_STATUS && !reg_wdata_in[BIT_A1F]
         && !(second_tick_in && alarm1_hit_in) |=> !alarm1_match_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("alarm 1 flag not cleared by zero write");

   property p_alarm_set;
      second_tick_in && alarm2_hit_in && !frozen |=> alarm2_match_flag;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm 2 flag missed a match");

   property p_irq_a1;
      !on_batt && interrupt_mode_select && alarm1_irq_en && alarm1_match_flag
         |=> irq_or_wave_n_oe_out && !irq_or_wave_n_out;
   endproperty
   a_irq_a1: assert property (p_irq_a1) else $error("pin not pulled low for alarm 1");

   property p_temp_ro;
      reg_wr_in && !ptr_load_in && reg_ptr_out == ADDR_TEMP_INT && state != ST_MEASURE |=> $stable(temp_reg);
   endproperty
   a_temp_ro: assert property (p_temp_ro) else $error("temperature changed by a write");

   property p_ptr_wrap;
      reg_rd_in && !ptr_load_in && reg_ptr_out == ADDR_TEMP_FRAC |=> reg_ptr_out == ADDR_FIRST;
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap to zero");

   property p_osf_set;
      osc_run_out && frozen |=> osc_stopped_flag;
   endproperty
   a_osf_set: assert property (p_osf_set) else $error("stop flag not set on oscillator stop");

   property p_batt_float;
      on_batt && !(battery_square_wave_en && !interrupt_mode_select) |=> !irq_or_wave_n_oe_out;
   endproperty
   a_batt_float: assert property (p_batt_float) else $error("pin driven on battery");

endmodule : rtc_control_status_regs

// [verif/temp_sensor_model.sv]
/*
 Behavioural temperature sensor facing the register bank.
 Assumes the bank holds its request level until it sees the done pulse.
*/
`timescale 1ns/1ps
module temp_sensor_model
#(
   parameter int DELAY = 50
)
(
   // Clock
   input  wire logic       clk_in,
   // Sensor handshake
   input  wire logic       force_temp_convert_in,
   input  wire logic [9:0] value_in,
   output logic            done_out,
   output logic      [9:0] temp_out
);
   int cnt = 0;
   // Result is only valid with done; otherwise inverted so no stale value passes
   always @(negedge clk_in)
   begin
      done_out <= 1'b0;
      temp_out <= ~value_in;
      cnt      <= 0;
      if (force_temp_convert_in && !done_out)
      begin
         cnt <= cnt + 1;
         if (cnt == DELAY)
         begin
            done_out <= 1'b1;
            temp_out <= value_in;
            cnt      <= 0;
         end
      end
   end
endmodule : temp_sensor_model

// [verif/rtc_control_status_regs_tb_top.sv]
/*
 Self-checking bench of the RTC control and status register bank.
 Assumes the register port pulse protocol and a sensor model on the far side.
*/
`timescale 1ns/1ps
module rtc_control_status_regs_tb_top;
   import rtc_regs_pkg::*;
   // Short busy delay keeps the run brief
   localparam int BUSY_CYC = 20;
   logic       clk_in = 0, osc_clk_in = 0, rstn_in = 0;
   logic       ptr_load_in = 0, reg_wr_in = 0, reg_rd_in = 0;
   logic       on_battery_in = 0, osc_fail_in = 0, second_tick_in = 0;
   logic       alarm1_hit_in = 0, alarm2_hit_in = 0;
   logic [7:0] ptr_value_in = 0, reg_wdata_in = 0, cap_base_in = 8'h40;
   logic [9:0] sensor_value = 10'h065, temp_value_in;
   logic [7:0] reg_rdata_out, reg_ptr_out, cap_code_out, d;
   logic       temp_force_temp_convert_out, temp_done_in, osc_run_out;
   logic       irq_or_wave_n_out, irq_or_wave_n_oe_out, clk32_out, clk32_oe_out;
   logic [7:0] rst_exp[5] = '{CONTROL_RST, 8'h8c, 8'h00, 8'h00, 8'h00};
   logic [7:0] ag[2] = '{8'hfe, 8'h03};
   logic [7:0] cap_exp[2] = '{8'h3e, 8'h43};
   logic [9:0] tv[2] = '{10'h3ff, 10'h1f6};
   int         num_errors = 0, n_checks = 0;

   always #5 clk_in = ~clk_in;
   initial
   begin
      #3;
      forever #15 osc_clk_in = ~osc_clk_in;
   end

   rtc_control_status_regs #(.USER_BUSY_CYCLES(BUSY_CYC)) u_rtc_control_status_regs
   (
      .clk_in, .osc_clk_in, .rstn_in, .ptr_load_in, .ptr_value_in, .reg_wr_in,
      .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .reg_ptr_out, .on_battery_in,
      .osc_fail_in, .second_tick_in, .alarm1_hit_in, .alarm2_hit_in, .temp_force_temp_convert_out,
      .temp_done_in, .temp_value_in, .cap_base_in, .cap_code_out, .osc_run_out,
      .irq_or_wave_n_out, .irq_or_wave_n_oe_out, .clk32_out, .clk32_oe_out
   );
   temp_sensor_model u_temp_sensor_model
   (
      .clk_in, .force_temp_convert_in(temp_force_temp_convert_out), .value_in(sensor_value),
      .done_out(temp_done_in), .temp_out(temp_value_in)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic set_ptr(input logic [7:0] a);
      @(negedge clk_in);
      ptr_load_in  = 1;
      ptr_value_in = a;
      @(negedge clk_in);
      ptr_load_in = 0;
   endtask : set_ptr
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      set_ptr(a);
      reg_wr_in    = 1;
      reg_wdata_in = v;
      @(negedge clk_in);
      reg_wr_in = 0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      set_ptr(a);
      reg_rd_in = 1;
      @(negedge clk_in);
      reg_rd_in = 0;
      check(reg_rdata_out, exp);
   endtask : rdc
   task automatic wait_force_temp_convert();
      for (int i = 0; i < 500 && temp_force_temp_convert_out !== 1'b0; i++)
         @(negedge clk_in);
      repeat (3) @(negedge clk_in);
      check(temp_force_temp_convert_out, 0);
   endtask : wait_force_temp_convert
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run

   initial
   begin
      #100us;
      num_errors++;
      complete_run();
   end

   initial
   begin
      repeat (16) @(negedge clk_in);
      rstn_in = 1;
      repeat (3) @(negedge clk_in);
      // Burst read from control through the last register, pointer wraps
      set_ptr(ADDR_CONTROL);
      reg_rd_in = 1;
      foreach (rst_exp[i])
      begin
         @(negedge clk_in);
         check(reg_rdata_out, rst_exp[i]);
      end
      reg_rd_in = 0;
      check(reg_ptr_out, ADDR_FIRST);
      $display("reset values done");

      // Convert request while the power-up conversion still runs is ignored
      wr(ADDR_CONTROL, 8'h3c);
      rdc(ADDR_CONTROL, 8'h1c);
      wait_force_temp_convert();
      rdc(ADDR_TEMP_INT, 8'h19);
      rdc(ADDR_TEMP_FRAC, 8'h40);
      rdc(ADDR_STATUS, 8'h88);
      wr(ADDR_TEMP_INT, 8'haa);
      wr(ADDR_TEMP_FRAC, 8'hff);
      rdc(ADDR_TEMP_INT, 8'h19);
      rdc(ADDR_TEMP_FRAC, 8'h40);
      $display("temperature done");

      // Clearing both sticky and enable bits; unused bits stay zero
      wr(ADDR_STATUS, 8'h70);
      rdc(ADDR_STATUS, 8'h00);
      repeat (20) @(negedge clk_in);
      check(clk32_oe_out, 0);
      wr(ADDR_STATUS, 8'h08);
      repeat (20) @(negedge clk_in);
      check(clk32_oe_out, 1);
      d = clk32_out;
      repeat (3) @(negedge clk_in);
      check(clk32_out ^ d[0], 1);
      $display("status done");

      for (int k = 0; k < 2; k++)
      begin
         wr(ADDR_CONTROL, 8'h04 | (8'h01 << k));
         alarm1_hit_in  = (k == 0);
         alarm2_hit_in  = (k == 1);
         second_tick_in = 1;
         @(negedge clk_in);
         second_tick_in = 0;
         alarm1_hit_in  = 0;
         alarm2_hit_in  = 0;
         rdc(ADDR_STATUS, 8'h08 | (8'h01 << k));
         check(irq_or_wave_n_out, 0);
         check(irq_or_wave_n_oe_out, 1);
         wr(ADDR_STATUS, 8'h0b);
         rdc(ADDR_STATUS, 8'h08 | (8'h01 << k));
         wr(ADDR_CONTROL, 8'h04);
         @(negedge clk_in);
         check(irq_or_wave_n_oe_out, 0);
         wr(ADDR_CONTROL, 8'h04 | (8'h01 << k));
         wr(ADDR_STATUS, 8'h08);
         rdc(ADDR_STATUS, 8'h08);
         check(irq_or_wave_n_oe_out, 0);
      end
      $display("alarms done");

      for (int i = 0; i < 2; i++)
      begin
         sensor_value = tv[i];
         wr(ADDR_AGING, ag[i]);
         wr(ADDR_CONTROL, 8'h3c);
         rdc(ADDR_CONTROL, 8'h3c);
         rdc(ADDR_STATUS, 8'h08);
         repeat (BUSY_CYC) @(negedge clk_in);
         rdc(ADDR_STATUS, 8'h0c);
         wait_force_temp_convert();
         rdc(ADDR_CONTROL, 8'h1c);
         rdc(ADDR_STATUS, 8'h08);
         check(cap_code_out, cap_exp[i]);
         rdc(ADDR_TEMP_INT, tv[i][9:2]);
         rdc(ADDR_TEMP_FRAC, {tv[i][1:0], 6'h00});
      end
      $display("conversion done");

      wr(ADDR_CONTROL, 8'h40);
      repeat (5) @(negedge clk_in);
      check(irq_or_wave_n_oe_out, 1);
      on_battery_in = 1;
      repeat (10) @(negedge clk_in);
      check(irq_or_wave_n_oe_out, 1);
      // A bus access on battery starts a conversion
      rdc(ADDR_STATUS, 8'h08);
      repeat (2) @(negedge clk_in);
      check(temp_force_temp_convert_out, 1);
      on_battery_in = 0;
      wait_force_temp_convert();
      // Freeze: oscillator stopped on battery, writes must not land
      wr(ADDR_CONTROL, 8'h80);
      on_battery_in = 1;
      repeat (10) @(negedge clk_in);
      check(osc_run_out, 0);
      check(irq_or_wave_n_oe_out, 0);
      wr(ADDR_AGING, 8'h55);
      on_battery_in = 0;
      repeat (10) @(negedge clk_in);
      check(osc_run_out, 1);
      rdc(ADDR_AGING, 8'h03);
      set_ptr(ADDR_STATUS);
      reg_rd_in = 1;
      @(negedge clk_in);
      reg_rd_in = 0;
      d = reg_rdata_out;
      check(d & 8'h80, 8'h80);
      $display("battery done");
      complete_run();
   end
endmodule : rtc_control_status_regs_tb_top
